/* File: src/cte_params.svh */
// Constants of the coprocessor transfer executor
`ifndef CTE_PARAMS_SVH
`define CTE_PARAMS_SVH

// Instruction field positions
`define CTE_F_COND_HI 31
`define CTE_F_COND_LO 28
`define CTE_F_CLS_HI 27
`define CTE_F_CLS4_LO 24
`define CTE_F_CLS3_LO 25
`define CTE_F_P 24
`define CTE_F_U 23
`define CTE_F_N 22
`define CTE_F_W 21
`define CTE_F_L 20
`define CTE_F_BASE_HI 19
`define CTE_F_BASE_LO 16
`define CTE_F_RD_HI 15
`define CTE_F_RD_LO 12
`define CTE_F_UNIT_HI 11
`define CTE_F_UNIT_LO 8
`define CTE_F_OFS_HI 7
`define CTE_F_OFS_LO 0
`define CTE_F_RT 4

// Class codes and special numbers
`define CTE_CLS_XFER 3'h6
`define CTE_CLS_UNIT 4'he
`define CTE_CTRL_UNIT 4'hf
`define CTE_PC_REG 4'hf
`define CTE_CFG_PRIMARY 4'h1

// Address arithmetic
`define CTE_OFS_SHIFT 2
`define CTE_WORD_STEP 32'h4
`define CTE_BASE_PC_ADJ 32'h8
`define CTE_SRC_PC_ADJ 32'hc

// Timing of a control register access
`define CTE_INT_CYCLES 2'h3

// Software register map
`define CTE_OFS_CFG 4'h0
`define CTE_OFS_STAT 4'h4
`define CTE_CFG_RST 32'h0
`define CTE_CFG_ASSIST 0
`define CTE_STAT_BUSY 0
`define CTE_STAT_UNDEF 1
`define CTE_STAT_ABORT 2
`define CTE_FLAG_HI 31
`define CTE_FLAG_LO 28

`endif

/* File: src/cte_pkg.sv */
// Types of the coprocessor transfer executor
package cte_pkg;
    typedef enum logic [2:0] {
        CTE_IDLE,
        CTE_FETCH,
        CTE_INT,
        CTE_WALK
    } cte_state_t;

    typedef enum logic [1:0] {
        CTE_K_NONE,
        CTE_K_SKIP,
        CTE_K_CTRL,
        CTE_K_UNDEF
    } cte_kind_t;
endpackage : cte_pkg

/* File: src/cte_cond_eval.sv */
// Condition field test against the NZCV flags
`timescale 1ns/100ps
module cte_cond_eval (
    input  wire logic [3:0] cond,
    input  wire logic [3:0] nzcv,
    output logic            pass
);
    logic n, z, c, v;
    assign {n, z, c, v} = nzcv;

    // Standard sixteen condition codes, last one never passes
    always_comb begin
        case (cond)
            4'h0:    pass = z;
            4'h1:    pass = !z;
            4'h2:    pass = c;
            4'h3:    pass = !c;
            4'h4:    pass = n;
            4'h5:    pass = !n;
            4'h6:    pass = v;
            4'h7:    pass = !v;
            4'h8:    pass = c && !z;
            4'h9:    pass = !c || z;
            4'ha:    pass = (n == v);
            4'hb:    pass = (n != v);
            4'hc:    pass = !z && (n == v);
            4'hd:    pass = z || (n != v);
            4'he:    pass = 1'b1;
            default: pass = 1'b0;
        endcase
    end
endmodule : cte_cond_eval

/* File: src/cte_addr_gen.sv */
// First transfer address and modified base for load/store
`timescale 1ns/100ps
`include "cte_params.svh"
module cte_addr_gen (
    input  wire logic [31:0] base,
    input  wire logic [7:0]  ofs_words,
    input  wire logic        up,
    input  wire logic        pre,
    output logic [31:0]      xfer_addr,
    output logic [31:0]      mod_base
);
    logic [31:0] scaled;

    // Unsigned word count scaled to bytes
    assign scaled = {24'h0, ofs_words} << `CTE_OFS_SHIFT;
    // Plain 32-bit sum, carry dropped on purpose
    assign mod_base = up ? base + scaled : base - scaled;
    // Low bits are never masked; misaligned bases pass through
    assign xfer_addr = pre ? mod_base : base;
endmodule : cte_addr_gen

/* File: src/cte_exec.sv */
// Coprocessor transfer executor: decode, control unit, address walk
`timescale 1ns/100ps
`include "cte_params.svh"
module cte_exec (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        instr_valid,
    output logic             instr_ready,
    input  wire logic [31:0] instr_word,
    input  wire logic [31:0] instr_pc,
    input  wire logic [3:0]  flags_in,
    input  wire logic [31:0] src_reg_data,
    output logic             instr_done,
    output logic             undef_trap,
    output logic             rd_we,
    output logic [3:0]       rd_idx,
    output logic [31:0]      rd_data,
    output logic             flags_we,
    output logic [3:0]       flags_out,
    input  wire logic        walk_start,
    output logic             walk_ready,
    input  wire logic [31:0] walk_instr,
    input  wire logic [31:0] walk_pc,
    input  wire logic [31:0] walk_base,
    input  wire logic [3:0]  walk_words,
    output logic             walk_done,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic             mem_write,
    output logic             mem_long,
    output logic [3:0]       mem_unit,
    input  wire logic        mem_abort,
    output logic             abort_trap,
    output logic             base_we,
    output logic [3:0]       base_idx,
    output logic [31:0]      base_data,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);
    cte_pkg::cte_state_t state_reg;
    cte_pkg::cte_kind_t  kind;
    logic        cond_ok;
    logic        acc;
    logic        walk_go;
    logic        is_rt;
    logic        is_xfer;
    logic        is_unit;
    logic [3:0]  unit_no;
    logic [1:0]  int_cnt_reg;
    logic [31:0] cfg_reg;
    logic        undef_seen_reg;
    logic        abort_seen_reg;
    logic [31:0] op_word_reg;
    logic [31:0] op_pc_reg;
    logic [31:0] op_src_reg;
    logic [31:0] xfer_word_reg;
    logic [31:0] pc_base;
    logic [31:0] start_addr;
    logic [31:0] start_mod;
    logic [31:0] walk_mod_reg;
    logic [3:0]  walk_cnt_reg;
    logic        walk_w_reg;
    logic [3:0]  walk_bidx_reg;
    logic        walk_end;
    logic        cfg_hit;

    // Condition test of the offered instruction
    cte_cond_eval u_cond (
        .cond (instr_word[`CTE_F_COND_HI:`CTE_F_COND_LO]),
        .nzcv (flags_in),
        .pass (cond_ok)
    );

    // Program counter base reads as instruction address plus eight
    assign pc_base = (walk_instr[`CTE_F_BASE_HI:`CTE_F_BASE_LO] == `CTE_PC_REG) ?
                     walk_pc + `CTE_BASE_PC_ADJ : walk_base;

    cte_addr_gen u_addr (
        .base      (pc_base),
        .ofs_words (walk_instr[`CTE_F_OFS_HI:`CTE_F_OFS_LO]),
        .up        (walk_instr[`CTE_F_U]),
        .pre       (walk_instr[`CTE_F_P]),
        .xfer_addr (start_addr),
        .mod_base  (start_mod)
    );

    // Instruction class decode
    assign is_unit = instr_word[`CTE_F_CLS_HI:`CTE_F_CLS4_LO] == `CTE_CLS_UNIT;
    assign is_rt   = is_unit && instr_word[`CTE_F_RT];
    assign is_xfer = instr_word[`CTE_F_CLS_HI:`CTE_F_CLS3_LO] == `CTE_CLS_XFER;
    assign unit_no = instr_word[`CTE_F_UNIT_HI:`CTE_F_UNIT_LO];

    // Only the control unit answers; every other coprocessor form traps
    always_comb begin
        if (!cond_ok) begin
            kind = cte_pkg::CTE_K_SKIP;
        end else if (is_rt && unit_no == `CTE_CTRL_UNIT) begin
            kind = cte_pkg::CTE_K_CTRL;
        end else if (is_rt || is_xfer || is_unit) begin
            kind = cte_pkg::CTE_K_UNDEF;
        end else begin
            kind = cte_pkg::CTE_K_NONE;
        end
    end

    // Offered instructions win over a walk request in the same cycle
    assign instr_ready = (state_reg == cte_pkg::CTE_IDLE);
    assign acc         = instr_valid && instr_ready;
    assign walk_ready  = instr_ready && !instr_valid && cfg_reg[`CTE_CFG_ASSIST];
    assign walk_go     = walk_start && walk_ready;
    assign walk_end    = mem_abort || (walk_cnt_reg <= 4'h1);

    // Sequencer: control access is one fetch then three internal cycles
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= cte_pkg::CTE_IDLE;
            int_cnt_reg <= 2'h0;
        end else begin
            case (state_reg)
                cte_pkg::CTE_IDLE: begin
                    int_cnt_reg <= 2'h0;
                    if (acc && kind == cte_pkg::CTE_K_CTRL) begin
                        state_reg <= cte_pkg::CTE_FETCH;
                    end else if (walk_go) begin
                        state_reg <= cte_pkg::CTE_WALK;
                    end
                end
                cte_pkg::CTE_FETCH: begin
                    state_reg <= cte_pkg::CTE_INT;
                end
                cte_pkg::CTE_INT: begin
                    int_cnt_reg <= int_cnt_reg + 2'h1;
                    if (int_cnt_reg == `CTE_INT_CYCLES - 2'h1) begin
                        state_reg <= cte_pkg::CTE_IDLE;
                    end
                end
                cte_pkg::CTE_WALK: begin
                    if (walk_end) begin
                        state_reg <= cte_pkg::CTE_IDLE;
                    end
                end
                default: state_reg <= cte_pkg::CTE_IDLE;
            endcase
        end
    end

    // Operand capture; program counter as source is sent as PC+12
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            op_word_reg <= 32'h0;
            op_pc_reg   <= 32'h0;
            op_src_reg  <= 32'h0;
        end else if (acc) begin
            op_word_reg <= instr_word;
            op_pc_reg   <= instr_pc;
            if (instr_word[`CTE_F_RD_HI:`CTE_F_RD_LO] == `CTE_PC_REG) begin
                op_src_reg <= instr_pc + `CTE_SRC_PC_ADJ;
            end else begin
                op_src_reg <= src_reg_data;
            end
        end
    end

    // Control register hit: unit-side register select
    assign cfg_hit = op_word_reg[`CTE_F_BASE_HI:`CTE_F_BASE_LO] == `CTE_CFG_PRIMARY;

    // Word read from the control unit, sampled in the fetch cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            xfer_word_reg <= 32'h0;
        end else if (state_reg == cte_pkg::CTE_FETCH) begin
            xfer_word_reg <= cfg_hit ? cfg_reg : 32'h0;
        end
    end

    // Configuration word: core moves land on the last internal cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= `CTE_CFG_RST;
        end else if (state_reg == cte_pkg::CTE_INT &&
                     int_cnt_reg == `CTE_INT_CYCLES - 2'h1 &&
                     !op_word_reg[`CTE_F_L] && cfg_hit) begin
            cfg_reg <= op_src_reg;
        end else if (reg_wr && reg_addr == `CTE_OFS_CFG) begin
            cfg_reg <= reg_wdata;
        end
    end

    // Completion pulses and core register results
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            instr_done <= 1'b0;
            undef_trap <= 1'b0;
            rd_we      <= 1'b0;
            rd_idx     <= 4'h0;
            rd_data    <= 32'h0;
            flags_we   <= 1'b0;
            flags_out  <= 4'h0;
        end else begin
            instr_done <= 1'b0;
            undef_trap <= 1'b0;
            rd_we      <= 1'b0;
            flags_we   <= 1'b0;
            if (acc && kind != cte_pkg::CTE_K_CTRL) begin
                instr_done <= 1'b1;
                undef_trap <= (kind == cte_pkg::CTE_K_UNDEF);
            end else if (state_reg == cte_pkg::CTE_INT &&
                         int_cnt_reg == `CTE_INT_CYCLES - 2'h1) begin
                instr_done <= 1'b1;
                if (op_word_reg[`CTE_F_L]) begin
                    // Unit to core; program counter target takes only the flags
                    if (op_word_reg[`CTE_F_RD_HI:`CTE_F_RD_LO] == `CTE_PC_REG) begin
                        flags_we  <= 1'b1;
                        flags_out <= xfer_word_reg[`CTE_FLAG_HI:`CTE_FLAG_LO];
                    end else begin
                        rd_we   <= 1'b1;
                        rd_idx  <= op_word_reg[`CTE_F_RD_HI:`CTE_F_RD_LO];
                        rd_data <= xfer_word_reg;
                    end
                end
            end
        end
    end

    // Address walk; the unit owns the word count
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_addr     <= 32'h0;
            walk_cnt_reg <= 4'h0;
            walk_mod_reg <= 32'h0;
            walk_w_reg   <= 1'b0;
            walk_bidx_reg <= 4'h0;
            mem_write    <= 1'b0;
            mem_long     <= 1'b0;
            mem_unit     <= 4'h0;
        end else if (walk_go) begin
            mem_addr     <= start_addr;
            walk_cnt_reg <= walk_words;
            walk_mod_reg <= start_mod;
            walk_w_reg   <= walk_instr[`CTE_F_W];
            walk_bidx_reg <= walk_instr[`CTE_F_BASE_HI:`CTE_F_BASE_LO];
            mem_write    <= !walk_instr[`CTE_F_L];
            mem_long     <= walk_instr[`CTE_F_N];
            mem_unit     <= walk_instr[`CTE_F_UNIT_HI:`CTE_F_UNIT_LO];
        end else if (state_reg == cte_pkg::CTE_WALK && !walk_end) begin
            mem_addr     <= mem_addr + `CTE_WORD_STEP;
            walk_cnt_reg <= walk_cnt_reg - 4'h1;
        end
    end

    assign mem_req = (state_reg == cte_pkg::CTE_WALK);

    // Walk end: write-back only on W, also after an abort
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            walk_done  <= 1'b0;
            abort_trap <= 1'b0;
            base_we    <= 1'b0;
            base_idx   <= 4'h0;
            base_data  <= 32'h0;
        end else begin
            walk_done  <= 1'b0;
            abort_trap <= 1'b0;
            base_we    <= 1'b0;
            if (mem_req && walk_end) begin
                walk_done  <= 1'b1;
                abort_trap <= mem_abort;
                base_we    <= walk_w_reg;
                base_idx   <= walk_bidx_reg;
                base_data  <= walk_mod_reg;
            end
        end
    end

    // Event flags; a new event beats a software clear
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            undef_seen_reg <= 1'b0;
            abort_seen_reg <= 1'b0;
        end else begin
            if (undef_trap) begin
                undef_seen_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `CTE_OFS_STAT &&
                         reg_wdata[`CTE_STAT_UNDEF]) begin
                undef_seen_reg <= 1'b0;
            end
            if (abort_trap) begin
                abort_seen_reg <= 1'b1;
            end else if (reg_wr && reg_addr == `CTE_OFS_STAT &&
                         reg_wdata[`CTE_STAT_ABORT]) begin
                abort_seen_reg <= 1'b0;
            end
        end
    end

    // Read port; unmapped offsets read zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `CTE_OFS_CFG:  reg_rdata <= cfg_reg;
                `CTE_OFS_STAT: reg_rdata <= {29'h0, abort_seen_reg, undef_seen_reg,
                                             state_reg != cte_pkg::CTE_IDLE};
                default:       reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Checks of the documented behaviour
    property p_undef_unit;
        @(posedge ref_clk) disable iff (!resetn)
        acc && cond_ok && is_rt && unit_no != `CTE_CTRL_UNIT |=> undef_trap && instr_done;
    endproperty
    a_undef_unit: assert property (p_undef_unit) else $error("other unit did not trap");

    property p_undef_xfer;
        @(posedge ref_clk) disable iff (!resetn)
        acc && cond_ok && is_xfer |=> undef_trap;
    endproperty
    a_undef_xfer: assert property (p_undef_xfer) else $error("load/store did not trap");

    property p_skip;
        @(posedge ref_clk) disable iff (!resetn)
        acc && !cond_ok |=> instr_done && !undef_trap && !rd_we && !flags_we;
    endproperty
    a_skip: assert property (p_skip) else $error("failed condition had effect");

    property p_ctrl_time;
        @(posedge ref_clk) disable iff (!resetn)
        acc && kind == cte_pkg::CTE_K_CTRL |=> !instr_done [*4] ##1 instr_done;
    endproperty
    a_ctrl_time: assert property (p_ctrl_time) else $error("control access not 1+3 cycles");

    property p_flags;
        @(posedge ref_clk) disable iff (!resetn)
        flags_we |-> !rd_we && flags_out == xfer_word_reg[31:28];
    endproperty
    a_flags: assert property (p_flags) else $error("flags not from word top bits");

    property p_src_pc;
        @(posedge ref_clk) disable iff (!resetn)
        acc && kind == cte_pkg::CTE_K_CTRL && !instr_word[`CTE_F_L] &&
        instr_word[`CTE_F_BASE_HI:`CTE_F_BASE_LO] == `CTE_CFG_PRIMARY &&
        instr_word[`CTE_F_RD_HI:`CTE_F_RD_LO] == `CTE_PC_REG
        |-> ##5 cfg_reg == $past(instr_pc, 5) + 32'hc;
    endproperty
    a_src_pc: assert property (p_src_pc) else $error("PC source not PC+12");

    property p_first_addr;
        @(posedge ref_clk) disable iff (!resetn)
        walk_go |=> mem_req && mem_addr == $past(start_addr);
    endproperty
    a_first_addr: assert property (p_first_addr) else $error("first address wrong");

    property p_step;
        @(posedge ref_clk) disable iff (!resetn)
        mem_req && !walk_end |=> mem_req && mem_addr == $past(mem_addr) + 32'h4;
    endproperty
    a_step: assert property (p_step) else $error("address did not step one word");

    property p_abort;
        @(posedge ref_clk) disable iff (!resetn)
        mem_req && mem_abort |=> abort_trap && base_we == walk_w_reg && !mem_req;
    endproperty
    a_abort: assert property (p_abort) else $error("abort handling wrong");

    property p_wb;
        @(posedge ref_clk) disable iff (!resetn)
        base_we |-> walk_w_reg && walk_done && base_data == walk_mod_reg;
    endproperty
    a_wb: assert property (p_wb) else $error("write-back without W bit");

    c_undef: cover property (@(posedge ref_clk) disable iff (!resetn) undef_trap);
    c_ctrl: cover property (@(posedge ref_clk) disable iff (!resetn) rd_we || flags_we);
    c_abort: cover property (@(posedge ref_clk) disable iff (!resetn) abort_trap && base_we);
    c_walk: cover property (@(posedge ref_clk) disable iff (!resetn)
                            walk_done && !abort_trap);
endmodule : cte_exec

/* File: testbench/cte_unit_model.sv */
// Behavioural far-side unit: answers walk words, aborts on command
`timescale 1ns/100ps
module cte_unit_model #(
    parameter logic [3:0] UNIT = 4'h5
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       mem_req,
    input  wire logic [3:0] mem_unit,
    input  wire logic [3:0] abort_at,
    output logic            mem_abort
);
    logic [3:0] cnt_reg;

    // Word index within a walk; cleared between walks so a retry repeats exactly
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= mem_req ? cnt_reg + 4'h1 : 4'h0;
        end
    end

    // Only the unit whose number matches reacts; 4'hf never aborts
    assign mem_abort = mem_req && (mem_unit == UNIT) && (cnt_reg == abort_at);
endmodule : cte_unit_model

/* File: testbench/cte_exec_tb.sv */
// Self-checking bench for the coprocessor transfer executor
`timescale 1ns/100ps
module cte_exec_tb;
    logic ref_clk = 0, resetn = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0, walk_start = 0;
    logic [31:0] instr_word = 0, instr_pc = 0, src_reg_data = 0, reg_wdata = 0;
    logic [31:0] walk_instr = 0, walk_pc = 0, walk_base = 0, rdv;
    logic [3:0]  flags_in = 0, walk_words = 0, reg_addr = 0, abort_at = 4'hf;
    logic [3:0]  rd_idx, flags_out, mem_unit, base_idx;
    logic [31:0] rd_data, mem_addr, base_data, reg_rdata;
    logic instr_ready, instr_done, undef_trap, rd_we, flags_we, walk_ready, walk_done;
    logic mem_req, mem_write, mem_long, mem_abort, abort_trap, base_we, g_und, g_rwe, g_fwe;
    int failures = 0, compares = 0, cycles = 0, dn;

    cte_exec i_dut (.*);
    cte_unit_model i_unit (.ref_clk(ref_clk), .resetn(resetn), .mem_req(mem_req),
        .mem_unit(mem_unit), .abort_at(abort_at), .mem_abort(mem_abort));

    always #10 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    // Hang guard: whole run is under a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask : bus_wr

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 rdv = reg_rdata;
    endtask : bus_rd

    function automatic logic [31:0] mk_rt(input logic [3:0] c, input logic l,
        input logic [3:0] rd, input logic [3:0] u);
        return {c, 4'he, 3'h0, l, 4'h1, rd, u, 3'h0, 1'b1, 4'h0};
    endfunction : mk_rt

    function automatic logic [31:0] mk_ls(input logic [4:0] punwl, input logic [3:0] bi,
        input logic [7:0] ofs);
        return {4'he, 3'h6, punwl, bi, 4'h2, 4'h5, ofs};
    endfunction : mk_ls

    task automatic ins(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] src,
        input logic [3:0] fl);
        @(posedge ref_clk);
        instr_valid <= 1; instr_word <= w; instr_pc <= pc; src_reg_data <= src; flags_in <= fl;
        @(posedge ref_clk);
        instr_valid <= 0;
        dn = 1;
        #1;
        while (instr_done !== 1'b1 && dn < 12) begin
            @(posedge ref_clk);
            #1 dn++;
        end
        g_und = undef_trap; g_rwe = rd_we; g_fwe = flags_we;
    endtask : ins

    // Expected addresses are rebuilt here from the instruction fields
    task automatic walk(input logic [31:0] w, input logic [31:0] pc, input logic [31:0] b,
        input logic [3:0] nw, input logic [3:0] ab);
        logic [31:0] bs, md, a;
        int k, seen;
        bs = (w[19:16] == 4'hf) ? pc + 32'h8 : b;
        md = w[23] ? bs + {22'h0, w[7:0], 2'h0} : bs - {22'h0, w[7:0], 2'h0};
        a = w[24] ? md : bs;
        k = 0; seen = 0;
        @(posedge ref_clk);
        walk_start <= 1; walk_instr <= w; walk_pc <= pc; walk_base <= b;
        walk_words <= nw; abort_at <= ab;
        @(posedge ref_clk);
        walk_start <= 0;
        #1;
        while (walk_done !== 1'b1 && k < 20) begin
            if (mem_req === 1'b1) begin
                chk("addr", a, mem_addr);
                chk("long", 32'(w[22]), 32'(mem_long));
                chk("write", 32'(!w[20]), 32'(mem_write));
                chk("unit", 32'(w[11:8]), 32'(mem_unit));
                a = a + 32'h4;
                seen++;
            end
            k++;
            @(posedge ref_clk);
            #1;
        end
        chk("done", 32'h1, 32'(walk_done));
        chk("words", (ab < nw) ? 32'(ab) + 1 : 32'(nw), 32'(seen));
        chk("abort", 32'(ab < nw), 32'(abort_trap));
        chk("bwe", 32'(w[21]), 32'(base_we));
        if (w[21]) chk("bdata", md, base_data);
        chk("bidx", 32'(w[19:16]), 32'(base_idx));
    endtask : walk

    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1;
        @(posedge ref_clk);
        #1;
        chk("irdy", 32'h1, 32'(instr_ready));
        chk("wrdy", 32'h0, 32'(walk_ready));
        bus_wr(4'h0, 32'ha0000001);
        bus_rd(4'h0); chk("cfg", 32'ha0000001, rdv);
        bus_rd(4'h8); chk("unmapped", 32'h0, rdv);
        $display("test regs done");
        ins(mk_rt(4'he, 1, 4'h3, 4'hf), 0, 0, 0); chk("cyc", 5, dn);
        chk("rdwe", 1, 32'(g_rwe)); chk("rd", 32'ha0000001, rd_data);
        chk("rdidx", 32'h3, 32'(rd_idx));
        ins(mk_rt(4'he, 1, 4'hf, 4'hf), 0, 0, 0); chk("fwe", 1, 32'(g_fwe));
        chk("flags", 32'ha, 32'(flags_out)); chk("nordwe", 0, 32'(g_rwe));
        ins(mk_rt(4'he, 0, 4'hf, 4'hf), 32'h100, 0, 0); chk("cyc", 5, dn);
        bus_rd(4'h0); chk("pc12", 32'h10c, rdv);
        ins(mk_rt(4'he, 0, 4'h2, 4'hf), 0, 32'h1, 0);
        bus_rd(4'h0); chk("mcr", 32'h1, rdv);
        $display("test control unit done");
        ins(mk_rt(4'h0, 1, 4'h3, 4'h5), 0, 0, 4'h0); chk("skip", 0, 32'(g_und));
        chk("cyc", 1, dn);
        ins(mk_rt(4'h0, 1, 4'h3, 4'hf), 0, 0, 4'h0); chk("skiprd", 0, 32'(g_rwe));
        ins(mk_rt(4'he, 1, 4'h3, 4'h5), 0, 0, 0); chk("undef", 1, 32'(g_und));
        ins(mk_ls(5'h19, 4'h1, 8'h1), 0, 0, 0); chk("lsundef", 1, 32'(g_und));
        bus_rd(4'h4); chk("status", 32'h2, rdv);
        $display("test traps done");
        chk("wrdy_on", 32'h1, 32'(walk_ready));
        walk(mk_ls(5'h1f, 4'h5, 8'h06), 0, 32'h1000, 4'h2, 4'hf);
        walk(mk_ls(5'h00, 4'h5, 8'h03), 0, 32'h2000, 4'h3, 4'hf);
        walk(mk_ls(5'h0b, 4'hf, 8'hff), 32'h300, 32'h5, 4'h1, 4'hf);
        walk(mk_ls(5'h12, 4'h5, 8'h01), 0, 32'h2, 4'h2, 4'hf);
        walk(mk_ls(5'h1b, 4'h5, 8'h01), 0, 32'h4000, 4'h4, 4'h1);
        bus_rd(4'h4);
        chk("stat_abort", 32'h6, rdv);
        bus_wr(4'h4, 32'h6);
        bus_rd(4'h4);
        chk("stat_clr", 32'h0, rdv);
        walk(mk_ls(5'h1b, 4'h5, 8'h01), 0, 32'h4000, 4'h4, 4'hf);
        $display("test walks done");
        wrap_up();
    end
endmodule : cte_exec_tb
